/* File: microaddress_sequencer.sv */
// Functional notes
// - Drive 12-bit address from four sources
// - Step and branch across 4096 words
// - Carry-in high: counter takes address plus one, zero on code 0
// - Carry-in low: counter holds address, microinterrupt only
// - Loop register holds address or count
// - Nine-deep return stack
// - Branch bus is only external source
// - One condition per cycle decides branches
// - Control bits 15:12 select sixteen operations
// - Clear or abort forces instruction zero
// - Code 1 conditional call pushes counter
// - Code 2 jumps to branch bus
// - Code 4 pushes, conditionally loads loop
// - Code 6 conditional vector jump
// - Code 7 bus or loop register, no push
// - Codes 8/9 repeat until loop zero
// - Default: counter increments, state held
// - Codes A/B conditional return or pop-branch
// - Code C loads count, D loop test, E continue
// - Code F three-way branch
`timescale 1ns/1ns
`include "seq_consts.svh"
module microaddress_sequencer (
  input wire logic clk,
  input wire logic rst,
  seq_if.sequencer bus,
  output seq_pkg::addr_t microprogram_counter_out,
  output seq_pkg::addr_t loop_register_out
);
  seq_pkg::addr_t microprogram_counter;
  seq_pkg::addr_t next_microprogram_counter;
  seq_pkg::addr_t loop_register;
  seq_pkg::addr_t next_loop_register;
  seq_pkg::addr_t stack_top;
  seq_pkg::addr_t address;
  logic push;
  logic pop;
  logic clear;
  logic loop_zero;
  seq_pkg::seq_op_e op;

  // Loop register counts down by one; callers test for zero first,
  // except the three-way branch, which may wrap to all ones
  function automatic seq_pkg::addr_t count_down(input seq_pkg::addr_t value);
    return value - `ADDR_ONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode, combinational within the cycle
  assign op = seq_pkg::seq_op_e'(bus.instr);
  assign loop_zero = (loop_register == `ADDR_ZERO);

  always_comb begin
    address = microprogram_counter;
    next_loop_register = loop_register;
    push = 1'b0;
    pop = 1'b0;
    clear = 1'b0;
    // Condition drives the conditional choices below, except codes 8 and 9, which test loop zero only
    unique case (op)
      // Address, counter, loop register and stack pointer back to zero; from the control word or forced under clear or abort
      seq_pkg::jump_to_zero: begin
        address = `ADDR_ZERO;
        next_loop_register = `ADDR_ZERO;
        clear = 1'b1;
      end
      // Call: the counter already holds the return point
      seq_pkg::cond_call: begin
        if (bus.condition) begin
          address = bus.branch_bus;
          push = 1'b1;
        end
      end
      // Four-way dispatch; the bus carries the operand format
      seq_pkg::map_jump: begin
        address = bus.branch_bus;
      end
      // Plain conditional branch
      seq_pkg::cond_branch: begin
        if (bus.condition) begin
          address = bus.branch_bus;
        end
      end
      // Loop setup: push the loop start, maybe load the count
      seq_pkg::loop_setup: begin
        push = 1'b1;
        if (bus.condition) begin
          next_loop_register = bus.branch_bus;
        end
      end
      // Always pushes; false falls back to a preloaded target
      seq_pkg::call_or_counter_jump: begin
        push = 1'b1;
        address = bus.condition ? bus.branch_bus : loop_register;
      end
      // Vector dispatch from opcode or interrupt logic
      seq_pkg::cond_vector_jump: begin
        if (bus.condition) begin
          address = bus.branch_bus;
        end
      end
      // Stack untouched either way
      seq_pkg::branch_or_counter_target: begin
        address = bus.condition ? bus.branch_bus : loop_register;
      end
      // Back to the stack top until the count runs out
      seq_pkg::repeat_stack_loop: begin
        if (loop_zero) begin
          pop = 1'b1;
        end else begin
          address = stack_top;
          next_loop_register = count_down(loop_register);
        end
      end
      // Same, but the loop start comes from the bus
      seq_pkg::repeat_bus_loop: begin
        if (!loop_zero) begin
          address = bus.branch_bus;
          next_loop_register = count_down(loop_register);
        end
      end
      // Return pops the entry it jumps to
      seq_pkg::cond_return: begin
        if (bus.condition) begin
          address = stack_top;
          pop = 1'b1;
        end
      end
      // Branch out and discard the saved entry
      seq_pkg::cond_branch_pop: begin
        if (bus.condition) begin
          address = bus.branch_bus;
          pop = 1'b1;
        end
      end
      // Count load; the address just steps
      seq_pkg::load_loop_count: begin
        next_loop_register = bus.branch_bus;
      end
      // Bottom of loop: exit when true, else go round again
      seq_pkg::loop_test: begin
        if (bus.condition) begin
          pop = 1'b1;
        end else begin
          address = stack_top;
        end
      end
      // Nothing but a step
      seq_pkg::sequential_next: begin
        address = microprogram_counter;
      end
      // True exits even at zero, so the count may wrap to all ones
      seq_pkg::three_way_branch: begin
        if (bus.condition) begin
          pop = 1'b1;
          next_loop_register = count_down(loop_register);
        end else if (loop_zero) begin
          address = bus.branch_bus;
          pop = 1'b1;
        end else begin
          address = stack_top;
          next_loop_register = count_down(loop_register);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter follows the bus; carry-in low holds the return point
  always_comb begin
    if (clear) begin
      next_microprogram_counter = `ADDR_ZERO;
    end else if (bus.carry_in) begin
      next_microprogram_counter = address + `ADDR_ONE;
    end else begin
      next_microprogram_counter = address;
    end
  end

  // Counter and loop register registered on the microcycle edge
  always_ff @(posedge clk) begin
    if (rst) begin
      microprogram_counter <= `ADDR_ZERO;
      loop_register <= `ADDR_ZERO;
    end else begin
      microprogram_counter <= next_microprogram_counter;
      loop_register <= next_loop_register;
    end
  end

  // Stack shares the same edge
  return_stack stack (
    .clk(clk),
    .rst(rst),
    .clear(clear),
    .push(push),
    .pop(pop),
    .push_data(microprogram_counter),
    .top(stack_top)
  );

  // Address is combinational; the store gets the registered copy a cycle later
  assign bus.sequencer_address_bus = address;
  assign microprogram_counter_out = microprogram_counter;
  assign loop_register_out = loop_register;
endmodule

/* File: return_stack.sv */
`timescale 1ns/1ns
`include "seq_consts.svh"
module return_stack (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire seq_pkg::addr_t push_data,
  output seq_pkg::addr_t top
);
  seq_pkg::addr_t mem [`STACK_DEPTH];
  seq_pkg::addr_t next_mem [`STACK_DEPTH];
  logic [`SP_W-1:0] depth;
  logic [`SP_W-1:0] next_depth;

  ////////////////////////////////////////////////////////////////////////////
  // Shift-register stack: slot 0 is always the top
  always_comb begin
    next_mem = mem;
    next_depth = depth;
    if (clear) begin
      next_depth = `SP_ZERO;
    end else if (push) begin
      // Overflow drops the oldest entry, as a deeper nest is a microcode bug
      for (int i = `STACK_DEPTH - 1; i > 0; i--) begin
        next_mem[i] = mem[i-1];
      end
      next_mem[0] = push_data;
      if (depth != `SP_FULL) begin
        next_depth = depth + `SP_ONE;
      end
    end else if (pop) begin
      // Popping an empty stack leaves the pointer at zero
      for (int i = 0; i < `STACK_DEPTH - 1; i++) begin
        next_mem[i] = mem[i+1];
      end
      if (depth != `SP_ZERO) begin
        next_depth = depth - `SP_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `STACK_DEPTH; i++) begin
        mem[i] <= `ADDR_ZERO;
      end
      depth <= `SP_ZERO;
    end else begin
      mem <= next_mem;
      depth <= next_depth;
    end
  end

  assign top = mem[0];
endmodule

/* File: seq_consts.svh */
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define ADDR_W 12
`define STACK_DEPTH 9
`define SP_W 4
`define ADDR_ZERO 12'h000
`define ADDR_ONE 12'h001
`define SP_ZERO 4'h0
`define SP_ONE 4'h1
`define SP_FULL 4'h9
`define INSTR_LSB 12
`define INSTR_MSB 15
`define NEXT_FIELD_MSB 11
`define NEXT_FIELD_LSB 0
`define INSTR_ZERO 4'h0
`endif

/* File: seq_if.sv */
`timescale 1ns/1ns
interface seq_if;
  logic [11:0] sequencer_address_bus;
  logic [11:0] branch_bus;
  logic [3:0] instr;
  logic condition;
  logic carry_in;
  modport sequencer (
    output sequencer_address_bus,
    input branch_bus,
    input instr,
    input condition,
    input carry_in
  );
  modport control (
    input sequencer_address_bus,
    output branch_bus,
    output instr,
    output condition,
    output carry_in
  );
endinterface

/* File: seq_pkg.sv */
package seq_pkg;
  typedef logic [11:0] addr_t;
  typedef enum logic [3:0] {
    jump_to_zero = 4'h0,
    cond_call = 4'h1,
    map_jump = 4'h2,
    cond_branch = 4'h3,
    loop_setup = 4'h4,
    call_or_counter_jump = 4'h5,
    cond_vector_jump = 4'h6,
    branch_or_counter_target = 4'h7,
    repeat_stack_loop = 4'h8,
    repeat_bus_loop = 4'h9,
    cond_return = 4'ha,
    cond_branch_pop = 4'hb,
    load_loop_count = 4'hc,
    loop_test = 4'hd,
    sequential_next = 4'he,
    three_way_branch = 4'hf
  } seq_op_e;
endpackage

/* File: seq_properties.sv */
`timescale 1ns/1ns
module seq_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] sequencer_address_bus,
  input wire logic [11:0] branch_bus,
  input wire logic [3:0] instr,
  input wire logic condition,
  input wire logic carry_in
);
  logic [11:0] sa;
  assign sa = sequencer_address_bus;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Internal state is hidden, so sequences pin it down first
  a_zero_jump: assert property (instr == 4'h0 |-> sa == 12'h000)
    else $error("jump zero missed");
  a_bus_taken: assert property (
    (instr == 4'h2 || (condition && instr inside {4'h1, 4'h3, 4'h5, 4'h6, 4'h7})) |-> sa == branch_bus)
    else $error("branch bus not taken");
  a_step_count: assert property ((instr == 4'he && carry_in) ##1 instr == 4'he |-> sa == $past(sa) + 12'h001)
    else $error("counter did not step");
  a_hold_addr: assert property ((instr == 4'he && !carry_in) ##1 instr == 4'he |-> sa == $past(sa))
    else $error("counter did not hold");
  a_call_return: assert property (
    (instr == 4'he && carry_in) ##1 (instr == 4'h1 && condition) ##1 (instr == 4'ha && condition)
    |-> sa == $past(sa, 2) + 12'h001) else $error("bad return");
  a_loop_repeat: assert property (
    (instr == 4'hc && carry_in) ##1 instr == 4'h9
    |-> sa == ($past(branch_bus) == 12'h000 ? $past(sa) + 12'h001 : branch_bus)) else $error("bad repeat");
  a_loop_return: assert property (
    (instr == 4'he && carry_in) ##1 instr == 4'h4 ##1 (instr == 4'hd && !condition)
    |-> sa == $past(sa)) else $error("bad loop return");
  a_counter_target: assert property (
    (instr == 4'hc && carry_in) ##1 (instr == 4'h7 && !condition)
    |-> sa == $past(branch_bus)) else $error("bad counter target");
endmodule

/* File: sequencer_control.sv */
`timescale 1ns/1ns
`include "seq_consts.svh"
module sequencer_control (
  input wire logic clk,
  input wire logic rst,
  seq_if.control bus,
  input wire logic [15:0] control_word_latch,
  input wire logic condition_select,
  input wire logic microinterrupt,
  input wire logic system_clear_signal,
  input wire logic fatal_abort,
  input wire seq_pkg::addr_t branch_source,
  input wire logic use_next_field,
  output seq_pkg::addr_t fetch_address
);
  seq_pkg::addr_t fetch;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction field, zeroed under clear or abort
  always_comb begin
    if (system_clear_signal || fatal_abort) bus.instr = `INSTR_ZERO;
    else bus.instr = control_word_latch[`INSTR_MSB:`INSTR_LSB];
  end

  // Branch bus: next field or a selected driver
  always_comb begin
    bus.branch_bus = use_next_field ? control_word_latch[`NEXT_FIELD_MSB:`NEXT_FIELD_LSB] : branch_source;
    bus.condition = condition_select;
    bus.carry_in = !microinterrupt;
  end

  // Registered copy of the fetch address for the store
  always_ff @(posedge clk) begin
    if (rst) fetch <= `ADDR_ZERO;
    else fetch <= bus.sequencer_address_bus;
  end

  assign fetch_address = fetch;
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] cw = 16'h0000;
  logic cs = 1'h0, mi = 1'h0, clr = 1'h0, abt = 1'h0, unf = 1'h0;
  logic [3:0] md = 4'h0;
  logic [11:0] bsrc = 12'h000, fetch, upc, lreg, pc = 12'h000, last = 12'h000, r1, r2;
  logic [11:0] stk [10];
  int fail_count = 0, checked = 0, i;
  seq_if bus_if();
  microaddress_sequencer microaddress_sequencer_i (.clk(clk), .rst(rst), .bus(bus_if),
    .microprogram_counter_out(upc), .loop_register_out(lreg));
  sequencer_control sequencer_control_i (.clk(clk), .rst(rst), .bus(bus_if), .control_word_latch(cw),
    .condition_select(cs), .microinterrupt(mi), .system_clear_signal(clr), .fatal_abort(abt),
    .branch_source(bsrc), .use_next_field(unf), .fetch_address(fetch));
  seq_properties seq_properties_i (.clk(clk), .rst(rst), .sequencer_address_bus(bus_if.sequencer_address_bus),
    .branch_bus(bus_if.branch_bus), .instr(bus_if.instr), .condition(bus_if.condition), .carry_in(bus_if.carry_in));
  // 25 MHz clock
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One microcycle; md packs next field, abort, clear, interrupt
  task automatic op(input logic [3:0] code, input logic c, input logic [11:0] sb, input logic [11:0] exp);
    @(posedge clk);
    cw <= {code, md[3] ? sb : ~sb};
    cs <= c;
    bsrc <= md[3] ? ~sb : sb; // Unselected source carries the inverse, so a wrong pick shows
    {unf, abt, clr, mi} <= md;
    @(negedge clk);
    check(bus_if.sequencer_address_bus, exp);
    check(fetch, last);
    last = exp;
    pc = md[0] ? exp : exp + 12'h001;
  endtask
  task automatic fin_test;
    $display("test done at %0t", $time);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    md = 4'h2;
    op(4'he, 1'h0, 12'h000, 12'h000);
    md = 4'h4;
    op(4'he, 1'h0, 12'h000, 12'h000);
    md = 4'h0;
    op(4'h0, 1'h0, 12'h000, 12'h000);
    check(upc, 12'h000);
    op(4'h2, 1'h0, 12'h100, 12'h100);
    op(4'he, 1'h0, 12'h000, pc);
    check(upc, 12'h101);
    md = 4'h1;
    op(4'he, 1'h0, 12'h000, pc);
    md = 4'h0;
    op(4'he, 1'h0, 12'h000, pc);
    fin_test;
    op(4'h3, 1'h0, 12'h200, pc);
    op(4'h3, 1'h1, 12'h200, 12'h200);
    op(4'h6, 1'h1, 12'h300, 12'h300);
    op(4'h6, 1'h0, 12'h300, pc);
    md = 4'h8;
    op(4'h3, 1'h1, 12'h0ab, 12'h0ab);
    md = 4'h0;
    fin_test;
    op(4'h1, 1'h0, 12'h400, pc);
    r1 = pc;
    op(4'h1, 1'h1, 12'h400, 12'h400);
    op(4'he, 1'h0, 12'h000, pc);
    r2 = pc;
    op(4'h1, 1'h1, 12'h500, 12'h500);
    op(4'ha, 1'h1, 12'h000, r2);
    op(4'ha, 1'h0, 12'h000, pc);
    op(4'ha, 1'h1, 12'h000, r1);
    fin_test;
    // Ten pushes: deepest is lost, nine come back in order
    for (i = 0; i < 10; i++) begin
      stk[i] = pc;
      op(4'h4, 1'h0, 12'h000, pc);
    end
    for (i = 9; i > 0; i--) begin
      op(4'ha, 1'h1, 12'h000, stk[i]);
    end
    fin_test;
    r1 = pc;
    op(4'h4, 1'h0, 12'h000, pc);
    op(4'hc, 1'h0, 12'h003, pc);
    r2 = pc;
    op(4'h4, 1'h0, 12'h000, pc);
    check(lreg, 12'h003);
    for (i = 0; i < 3; i++) begin
      op(4'h8, 1'h0, 12'h000, r2);
    end
    op(4'h8, 1'h0, 12'h000, pc);
    op(4'ha, 1'h1, 12'h000, r1);
    op(4'hc, 1'h0, 12'h002, pc);
    op(4'h9, 1'h0, 12'h600, 12'h600);
    op(4'h9, 1'h0, 12'h600, 12'h600);
    op(4'h9, 1'h0, 12'h600, pc);
    fin_test;
    op(4'hc, 1'h0, 12'h700, pc);
    op(4'h7, 1'h0, 12'h000, 12'h700);
    op(4'h7, 1'h1, 12'h720, 12'h720);
    r1 = pc;
    op(4'h5, 1'h0, 12'h000, 12'h700);
    r2 = pc;
    op(4'h5, 1'h1, 12'h710, 12'h710);
    op(4'hb, 1'h1, 12'h730, 12'h730);
    op(4'ha, 1'h1, 12'h000, r1);
    fin_test;
    op(4'he, 1'h0, 12'h000, pc);
    r1 = pc;
    op(4'h4, 1'h1, 12'h005, pc);
    op(4'hd, 1'h0, 12'h000, r1);
    check(lreg, 12'h005);
    op(4'hd, 1'h1, 12'h000, pc);
    op(4'hc, 1'h0, 12'h001, pc);
    r2 = pc;
    op(4'h4, 1'h0, 12'h000, pc);
    op(4'hf, 1'h0, 12'h000, r2);
    op(4'hf, 1'h0, 12'h800, 12'h800);
    op(4'h4, 1'h0, 12'h000, pc);
    op(4'hf, 1'h1, 12'h000, pc);
    op(4'he, 1'h0, 12'h000, pc);
    check(lreg, 12'hfff);
    fin_test;
    stop_test;
  end
  // Hang guard
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    stop_test;
  end
endmodule
